//--- pkg/acc_pkg.sv
// Purpose: shared constants for the comparator control register bank
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes:   register byte address is four times the register index
package acc_pkg;

  // bus geometry
  localparam int          ADDR_W      = 10;
  localparam int          DATA_W      = 32;

  // register indices and the byte addresses derived from them
  localparam logic [7:0]  IDX_CTRL    = 8'h9b;
  localparam logic [7:0]  IDX_MODE    = 8'h9d;
  localparam logic [7:0]  IDX_MUX     = 8'h9f;
  localparam logic [ADDR_W-1:0] ADR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MODE = {IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MUX  = {IDX_MUX, 2'b00};

  // control register fields
  localparam int          CTL_EN      = 7;
  localparam int          CTL_OUT     = 6;
  localparam int          CTL_RISE    = 5;
  localparam int          CTL_FALL    = 4;
  localparam int          CTL_HYP_LO  = 2;
  localparam int          CTL_HYN_LO  = 0;

  // mode register fields
  localparam int          MD_RIE      = 5;
  localparam int          MD_FIE      = 4;
  localparam int          MD_MODE_LO  = 0;

  // multiplexer register fields
  localparam int          MX_NEG_LO   = 4;
  localparam int          MX_POS_LO   = 0;

  // reset values
  localparam logic [1:0]  HYST_RST    = 2'h0;
  localparam logic [1:0]  MODE_RST    = 2'h2;
  localparam logic [2:0]  SEL_RST     = 3'h0;

  // response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

//--- core/acc_top.sv
// Purpose: register bank and digital control for the on-chip comparator
// Assumes: CLK at 10 MHz, RST_N async active low, CE freezes all state
// Notes:   comparator raw output is asynchronous and resynchronised here
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  // clock, reset, enable
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  // axi4-lite read data
  output logic [DATA_W-1:0]      S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // comparator core side
  input  wire logic              RAW_ASYNC_OUTPUT,
  output logic                   CMP_ENABLE,
  output logic [1:0]             POS_HYSTERESIS_SEL,
  output logic [1:0]             NEG_HYSTERESIS_SEL,
  output logic [1:0]             RESPONSE_MODE_SEL,
  output logic [2:0]             NEG_INPUT_SELECT,
  output logic [2:0]             POS_INPUT_SELECT,
  output logic                   NEG_INPUT_VALID,
  output logic                   POS_INPUT_VALID,
  // port pin and interrupt
  output logic                   CMP_PIN_OUT,
  output logic                   CMP_IRQ
);
  // software state
  logic       en_reg,    en_next;      // comparator enable
  logic       rise_reg,  rise_next;    // sticky rising-edge flag
  logic       fall_reg,  fall_next;    // sticky falling-edge flag
  logic [1:0] hyp_reg,   hyp_next;     // positive hysteresis code
  logic [1:0] hyn_reg,   hyn_next;     // negative hysteresis code
  logic       rie_reg,   rie_next;     // rising interrupt enable
  logic       fie_reg,   fie_next;     // falling interrupt enable
  logic [1:0] mode_reg,  mode_next;    // response-time mode
  logic [2:0] nsel_reg,  nsel_next;    // negative mux code
  logic [2:0] psel_reg,  psel_next;    // positive mux code
  logic       nval_reg,  nval_next;    // negative code selects a pin
  logic       pval_reg,  pval_next;    // positive code selects a pin
  logic       irq_reg,   irq_next;     // interrupt request
  // comparator output path
  logic       sync1_reg;               // first stage, read only by sync2
  logic       sync2_reg;               // second stage, safe to use
  logic       out_reg,   out_next;     // gated, clocked output state
  logic       live;                    // synced output, low when disabled
  logic       rise_ev;                 // one-cycle rising event
  logic       fall_ev;                 // one-cycle falling event
  // bus state
  logic              awf_reg,  awf_next;   // write address held
  logic [ADDR_W-1:0] awa_reg,  awa_next;   // held write address
  logic              wf_reg,   wf_next;    // write data held
  logic [7:0]        wd_reg,   wd_next;    // held low data byte
  logic              ws_reg,   ws_next;    // held low byte strobe
  logic              awr_reg,  awr_next;   // awready
  logic              wr_reg,   wr_next;    // wready
  logic              bv_reg,   bv_next;    // bvalid
  logic [1:0]        br_reg,   br_next;    // bresp
  logic              arr_reg,  arr_next;   // arready
  logic              rv_reg,   rv_next;    // rvalid
  logic [1:0]        rr_reg,   rr_next;    // rresp
  logic [7:0]        rd_reg,   rd_next;    // read byte
  logic              commit;               // write performed this cycle
  logic              wmap;                 // write address is mapped
  logic              wctl;                 // byte write to control
  logic              wmd;                  // byte write to mode
  logic              wmx;                  // byte write to mux
  logic [7:0]        rbyte;                // decoded read byte
  logic              rmap;                 // read address is mapped
  // synchroniser: two flops only, nothing taps the first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (CE) begin
      sync1_reg <= RAW_ASYNC_OUTPUT;
      sync2_reg <= sync1_reg;
    end
  end
  // edges only while enabled: disabling leaves no false fall flag
  always_comb begin
    live    = sync2_reg & en_reg;
    rise_ev = en_reg & live & ~out_reg;
    fall_ev = en_reg & ~live & out_reg;
    out_next = live;
  end
  // write decode; only the low byte lane carries register bits
  always_comb begin
    commit = awf_reg & wf_reg & ~bv_reg;
    wmap   = (awa_reg == ADR_CTRL) | (awa_reg == ADR_MODE) |
             (awa_reg == ADR_MUX);
    wctl   = commit & ws_reg & (awa_reg == ADR_CTRL);
    wmd    = commit & ws_reg & (awa_reg == ADR_MODE);
    wmx    = commit & ws_reg & (awa_reg == ADR_MUX);
  end
  // register next values
  always_comb begin
    en_next   = en_reg;
    hyp_next  = hyp_reg;
    hyn_next  = hyn_reg;
    rie_next  = rie_reg;
    fie_next  = fie_reg;
    mode_next = mode_reg;
    nsel_next = nsel_reg;
    psel_next = psel_reg;
    if (wctl) begin
      en_next  = wd_reg[CTL_EN];
      hyp_next = wd_reg[CTL_HYP_LO +: 2];
      hyn_next = wd_reg[CTL_HYN_LO +: 2];
    end
    if (wmd) begin
      rie_next  = wd_reg[MD_RIE];
      fie_next  = wd_reg[MD_FIE];
      mode_next = wd_reg[MD_MODE_LO +: 2];
    end
    if (wmx) begin
      nsel_next = wd_reg[MX_NEG_LO +: 3];
      psel_next = wd_reg[MX_POS_LO +: 3];
    end
    // writing 0 clears, writing 1 is ignored; an edge wins over a clear
    rise_next = (rise_reg & ~(wctl & ~wd_reg[CTL_RISE])) | rise_ev;
    fall_next = (fall_reg & ~(wctl & ~wd_reg[CTL_FALL])) | fall_ev;
    // codes 000-011 reach a pin or the internal node, 1xx selects none
    nval_next = ~nsel_next[2];
    pval_next = ~psel_next[2];
    irq_next  = (rise_reg & rie_reg) | (fall_reg & fie_reg);
  end
  // register state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_reg   <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      hyp_reg  <= HYST_RST;
      hyn_reg  <= HYST_RST;
      rie_reg  <= 1'b0;
      fie_reg  <= 1'b0;
      mode_reg <= MODE_RST;
      nsel_reg <= SEL_RST;
      psel_reg <= SEL_RST;
      nval_reg <= 1'b1;
      pval_reg <= 1'b1;
      irq_reg  <= 1'b0;
      out_reg  <= 1'b0;
    end else if (CE) begin
      en_reg   <= en_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      hyp_reg  <= hyp_next;
      hyn_reg  <= hyn_next;
      rie_reg  <= rie_next;
      fie_reg  <= fie_next;
      mode_reg <= mode_next;
      nsel_reg <= nsel_next;
      psel_reg <= psel_next;
      nval_reg <= nval_next;
      pval_reg <= pval_next;
      irq_reg  <= irq_next;
      out_reg  <= out_next;
    end
  end
  // read decode; unused bits are constant zero
  always_comb begin
    rbyte = 8'h00;
    rmap  = 1'b1;
    case (S_AXI_ARADDR)
      ADR_CTRL: rbyte = {en_reg, out_reg, rise_reg, fall_reg,
                         hyp_reg, hyn_reg};
      ADR_MODE: rbyte = {2'b00, rie_reg, fie_reg,
                         2'b00, mode_reg};
      ADR_MUX:  rbyte = {1'b0, nsel_reg, 1'b0, psel_reg};
      default:  rmap  = 1'b0;
    endcase
  end
  // bus channel next values; a write commits once both halves are held
  always_comb begin
    awf_next = awf_reg;
    awa_next = awa_reg;
    wf_next  = wf_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    rv_next  = rv_reg;
    rr_next  = rr_reg;
    rd_next  = rd_reg;
    if (S_AXI_AWVALID & awr_reg) begin
      awf_next = 1'b1;
      awa_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & wr_reg) begin
      wf_next = 1'b1;
      wd_next = S_AXI_WDATA[7:0];
      ws_next = S_AXI_WSTRB[0];
    end
    if (commit) begin
      awf_next = 1'b0;
      wf_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = wmap ? RESP_OKAY : RESP_SLVERR;
    end else if (bv_reg & S_AXI_BREADY) begin
      bv_next = 1'b0;
    end
    if (S_AXI_ARVALID & arr_reg) begin
      rv_next = 1'b1;
      rd_next = rbyte;
      rr_next = rmap ? RESP_OKAY : RESP_SLVERR;
    end else if (rv_reg & S_AXI_RREADY) begin
      rv_next = 1'b0;
    end
    // one write and one read at a time; ready drops while busy
    awr_next = ~awf_next & ~bv_next;
    wr_next  = ~wf_next & ~bv_next;
    arr_next = ~rv_next;
  end
  // bus channel state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      awf_reg <= 1'b0;
      awa_reg <= '0;
      wf_reg  <= 1'b0;
      wd_reg  <= 8'h00;
      ws_reg  <= 1'b0;
      awr_reg <= 1'b1;
      wr_reg  <= 1'b1;
      bv_reg  <= 1'b0;
      br_reg  <= RESP_OKAY;
      arr_reg <= 1'b1;
      rv_reg  <= 1'b0;
      rr_reg  <= RESP_OKAY;
      rd_reg  <= 8'h00;
    end else if (CE) begin
      awf_reg <= awf_next;
      awa_reg <= awa_next;
      wf_reg  <= wf_next;
      wd_reg  <= wd_next;
      ws_reg  <= ws_next;
      awr_reg <= awr_next;
      wr_reg  <= wr_next;
      bv_reg  <= bv_next;
      br_reg  <= br_next;
      arr_reg <= arr_next;
      rv_reg  <= rv_next;
      rr_reg  <= rr_next;
      rd_reg  <= rd_next;
    end
  end
  // outputs, each straight from a flop
  assign S_AXI_AWREADY      = awr_reg;
  assign S_AXI_WREADY       = wr_reg;
  assign S_AXI_BVALID       = bv_reg;
  assign S_AXI_BRESP        = br_reg;
  assign S_AXI_ARREADY      = arr_reg;
  assign S_AXI_RVALID       = rv_reg;
  assign S_AXI_RRESP        = rr_reg;
  assign S_AXI_RDATA        = {24'h000000, rd_reg};
  assign CMP_ENABLE         = en_reg;
  assign POS_HYSTERESIS_SEL = hyp_reg;
  assign NEG_HYSTERESIS_SEL = hyn_reg;
  assign RESPONSE_MODE_SEL  = mode_reg;
  assign NEG_INPUT_SELECT   = nsel_reg;
  assign POS_INPUT_SELECT   = psel_reg;
  assign NEG_INPUT_VALID    = nval_reg;
  assign POS_INPUT_VALID    = pval_reg;
  assign CMP_PIN_OUT        = out_reg;
  assign CMP_IRQ            = irq_reg;
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_PIN_LOW_OFF: assert property (CE & !en_reg |=> !CMP_PIN_OUT)
    else $error("pin output high while comparator disabled");
  AST_OUT_FOLLOWS: assert property (CE |=> out_reg == $past(live))
    else $error("output state does not follow synced input");
  AST_RISE_SET: assert property (CE & rise_ev |=> rise_reg)
    else $error("rising edge lost");
  AST_RISE_HOLD: assert property (CE & rise_reg & !wctl |=> rise_reg)
    else $error("rise flag dropped without a clear");
  AST_FALL_SET: assert property (CE & fall_ev |=> fall_reg)
    else $error("falling edge lost");
  AST_FALL_HOLD: assert property (CE & fall_reg & !wctl |=> fall_reg)
    else $error("fall flag dropped without a clear");
  AST_IRQ_OR: assert property (CE |=> CMP_IRQ ==
      ($past(rise_reg & rie_reg) | $past(fall_reg & fie_reg)))
    else $error("interrupt not the OR of enabled flags");
  AST_RISE_ONE: assert property (CE & rise_ev |=> !rise_ev)
    else $error("rising event lasted more than one cycle");
  AST_MODE_ZERO: assert property ($rose(rv_reg) &
      $past(S_AXI_ARADDR) == ADR_MODE |-> S_AXI_RDATA[7:6] == 2'b00)
    else $error("unused mode bits read nonzero");
  AST_MUX_ZERO: assert property ($rose(rv_reg) &
      $past(S_AXI_ARADDR) == ADR_MUX |-> !S_AXI_RDATA[7] && !S_AXI_RDATA[3])
    else $error("unused mux bits read nonzero");
  AST_PVALID: assert property (CE |=> POS_INPUT_VALID == !psel_reg[2])
    else $error("positive valid disagrees with code");
endmodule

`default_nettype wire

//--- tb/acc_cmp_model.sv
// Purpose: behavioural comparator core with its input multiplexer
// Assumes: the bench sets pos_above as the analog input relation
// Notes:   an unpowered or unrouted core shows the inverse, never a clean 0
`timescale 1ns/1ns
`default_nettype none
module acc_cmp_model (
  // control from the register bank
  input  wire logic cmp_enable,
  input  wire logic pos_valid,
  input  wire logic neg_valid,
  // analog stimulus and raw output
  input  wire logic pos_above,
  output logic      raw_out
);
  // a dead core is no kinder than silicon: garbage must be ignored upstream
  always_comb begin
    if (cmp_enable && pos_valid && neg_valid) begin
      raw_out = pos_above;
    end else begin
      raw_out = ~pos_above;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the comparator register bank
// Assumes: bus master drives by nonblocking assignment after rising edges
// Notes:   bready and rready stay high, so each reply is taken at once
`timescale 1ns/1ns
`default_nettype none
module tb
  import acc_pkg::*;
;
  // bus and port signals
  logic              clk, rst_n, pos_above, raw;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp, rs, hyp, hyn, mdsel;
  logic [2:0]        nsel, psel;
  logic              en, nval, pval, pin, irq, ce;
  int                n_fail, checks;

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  acc_top dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .RAW_ASYNC_OUTPUT(raw),
    .CMP_ENABLE(en), .POS_HYSTERESIS_SEL(hyp), .NEG_HYSTERESIS_SEL(hyn),
    .RESPONSE_MODE_SEL(mdsel), .NEG_INPUT_SELECT(nsel),
    .POS_INPUT_SELECT(psel), .NEG_INPUT_VALID(nval),
    .POS_INPUT_VALID(pval), .CMP_PIN_OUT(pin), .CMP_IRQ(irq)
  );

  acc_cmp_model model (
    .cmp_enable(en), .pos_valid(pval), .neg_valid(nval),
    .pos_above(pos_above), .raw_out(raw)
  );

  // compare data or port values
  task automatic chk_v(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare response codes
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  // one write; address and data released each when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done  = 0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  // one read; data taken at the edge where rvalid is seen
  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  // read and expect a mapped value
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rd_reg(a, rd, rs);
    chk_v(rd, {24'h0, e});
    chk_r(rs, RESP_OKAY);
  endtask

  // full-strobe write expecting okay
  task automatic wok(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr(a, d, 4'hf, rs);
    chk_r(rs, RESP_OKAY);
  endtask

  // margin over the three-edge sync path plus the irq register
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  // print counts and verdict, then end the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("mismatch at %0t: watchdog %h expected %h", $time, 0, 1);
    stop_test();
  end

  // main sequence
  initial begin
    {rst_n, pos_above, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, arvalid} = '0;
    bready = 1'b1;
    ce     = 1'b1;
    rready = 1'b1;
    n_fail = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(ADR_CTRL, 8'h00);
    rchk(ADR_MODE, 8'h02);
    rchk(ADR_MUX, 8'h00);
    chk_v(32'(en), 32'h0);
    // unmapped place and a write with the low strobe off
    wr(10'h000, 8'hff, 4'hf, rs);
    chk_r(rs, RESP_SLVERR);
    rd_reg(10'h000, rd, rs);
    chk_v(rd, 32'h0);
    chk_r(rs, RESP_SLVERR);
    wr(ADR_CTRL, 8'h8f, 4'he, rs);
    chk_r(rs, RESP_OKAY);
    rchk(ADR_CTRL, 8'h00);
    $display("test reset and refusals done");
    // every hysteresis code; writing 1 to clear flags must not set them
    for (int i = 0; i < 4; i++) begin
      wok(ADR_CTRL, {4'h3, 2'(i), 2'(3 - i)});
      rchk(ADR_CTRL, {4'h0, 2'(i), 2'(3 - i)});
      chk_v({28'h0, hyp, hyn}, {28'h0, 2'(i), 2'(3 - i)});
    end
    // every response mode, unused bits written as ones
    for (int i = 0; i < 4; i++) begin
      wok(ADR_MODE, {2'h3, i[0], i[1], 2'h3, 2'(i)});
      rchk(ADR_MODE, {2'h0, i[0], i[1], 2'h0, 2'(i)});
      chk_v(32'(mdsel), 32'(i));
    end
    wok(ADR_MODE, 8'h00);
    // every select code on both inputs
    for (int i = 0; i < 8; i++) begin
      wok(ADR_MUX, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
      rchk(ADR_MUX, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      chk_v({30'h0, nval, pval}, {30'h0, i<4, 7-i<4});
      chk_v({26'h0, nsel, psel}, {26'h0, 3'(i), 3'(7 - i)});
    end
    $display("test fields done");
    // rail pair: internal node on positive, code 011 on negative
    wok(ADR_MUX, 8'h33);
    wok(ADR_CTRL, 8'h80);
    settle();
    chk_v(32'(en), 32'h1);
    wok(ADR_CTRL, 8'h80);
    rchk(ADR_CTRL, 8'h80);
    pos_above <= 1'b1;
    settle();
    rchk(ADR_CTRL, 8'he0);
    chk_v({30'h0, pin, irq}, 32'h2);
    wok(ADR_MODE, 8'h20);
    settle();
    chk_v(32'(irq), 32'h1);
    wok(ADR_CTRL, 8'hb0);
    rchk(ADR_CTRL, 8'he0);
    wok(ADR_CTRL, 8'h80);
    settle();
    rchk(ADR_CTRL, 8'hc0);
    chk_v(32'(irq), 32'h0);
    pos_above <= 1'b0;
    settle();
    rchk(ADR_CTRL, 8'h90);
    chk_v({30'h0, pin, irq}, 32'h0);
    wok(ADR_MODE, 8'h10);
    settle();
    chk_v(32'(irq), 32'h1);
    wok(ADR_CTRL, 8'h80);
    settle();
    rchk(ADR_CTRL, 8'h80);
    chk_v(32'(irq), 32'h0);
    // frozen clock enable: an input edge waits until the clock runs again
    ce        <= 1'b0;
    pos_above <= 1'b1;
    settle();
    chk_v({30'h0, pin, irq}, 32'h0);
    ce <= 1'b1;
    settle();
    rchk(ADR_CTRL, 8'he0);
    wok(ADR_CTRL, 8'h80);
    $display("test edges done");
    // disabled: core garbage must reach neither pin nor flags
    wok(ADR_MODE, 8'h30);
    wok(ADR_CTRL, 8'h00);
    pos_above <= 1'b1;
    settle();
    chk_v({30'h0, pin, irq}, 32'h0);
    pos_above <= 1'b0;
    settle();
    rchk(ADR_CTRL, 8'h00);
    chk_v({30'h0, pin, irq}, 32'h0);
    $display("test disable done");
    stop_test();
  end
endmodule
`default_nettype wire
